// ---- scsi_irq_cfg.svh ----
// Function
// R01: Masked condition sets status, never the request.
// R02: Enable bit set lets condition raise request.
// R03: Masked condition sets pending, non-fatal excepted.
// R04: Stacking starts once scsi or dma pending.
// R05: Request latched until status register read.
// R06: Clearing enable leaves asserted request alone.
// R07: Masking occurred non-fatal drops pending, unstacks.
// R08: Bit 7: phase mismatch or attention asserted.
// R09: Bit 6: arbitration and selection completed.
// R10: Bit 5: selected, needs selection response enable.
// R11: Bit 4: reselected, needs reselection response enable.
// R12: Bit 3: any of six gross errors.
// R13: Bit 2: unexpected disconnect, any in low-level.
// R14: Bit 1: one interrupt per reset edge.
// R15: Bit 0: parity error when checking enabled.
// R16: Second enable gates timeouts, never pending flag.
// R17: Selection timeout when target fails to respond.
// R18: General timer expiry raises its condition.
// R19: Handshake timer expiry raises its condition.
// R20: Status read shows conditions regardless of enable.
// R21: Pending flag clears after both status reads.
// R22: Read clears seen bits, stacked ones appear.
// R23: Software spaces reads, reads scsi before dma.
// R24: Condition during clearing read is kept.
// R25: Software sets enables only at initialization.
`ifndef SCSI_IRQ_CFG_SVH
`define SCSI_IRQ_CFG_SVH
// Register indices; the byte address is the index shifted left.
`define REG_SHIFT 2
`define IDX_ADDER 12'h03c
`define IDX_EN_A 12'h040
`define IDX_EN_B 12'h041
`define IDX_ST_A 12'h042
`define IDX_ST_B 12'h043
`define IDX_SUMMARY 12'h045
`define IDX_MODE 12'h046
// Reset values.
`define EN_A_RST 8'h00
`define EN_B_RST 3'h0
`define ST_A_RST 8'h00
`define ST_B_RST 3'h0
`define MODE_RST 8'h00
// Condition layout of the first status register.
`define MASK_MA 8'h80
`define MASK_FATAL_A 8'h0f
`define BIT_MA 7
`define BIT_DONE 6
`define BIT_SEL 5
`define BIT_RESEL 4
`define BIT_GROSS 3
`define BIT_DISC 2
`define BIT_RST 1
`define BIT_PARITY 0
// Summary register bits.
`define BIT_SCSI_PEND 1
`define BIT_DMA_PEND 0
// Mode register fields.
`define MODE_INIT 0
`define MODE_LOWLVL 1
`define MODE_PAR_EN 2
`define MODE_SEL_EN 3
`define MODE_RESEL_EN 4
`define MODE_PHASE_LO 5
`define MODE_PHASE_HI 7
`endif

// ---- scsi_irq_pkg.sv ----
package scsi_irq_pkg;
  // Eight-bit register byte.
  typedef logic [7:0] byte_t;
  // Three timer conditions of the second register pair.
  typedef logic [2:0] tmr_t;
  // Whole state of the register and interrupt core.
  typedef struct packed {
    byte_t scsi_irq_enable_a;
    tmr_t scsi_irq_enable_b;
    byte_t scsi_irq_status_a;
    tmr_t scsi_irq_status_b;
    byte_t stack_a;
    tmr_t stack_b;
    byte_t mode;
    logic scsi_pending_flag;
    logic seen_a;
    logic seen_b;
    logic irq;
    logic [31:0] prdata;
  } core_state_s;
  // State of the condition capture stage.
  typedef struct packed {
    logic rst_prev;
    logic atn_prev;
    byte_t ev_a;
    tmr_t ev_b;
  } capture_state_s;
endpackage : scsi_irq_pkg

// ---- scsi_condition_capture.sv ----
`timescale 1ns/10ps
`include "scsi_irq_cfg.svh"
module scsi_condition_capture import scsi_irq_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Mode settings.
  input wire byte_t mode,
  // Raw condition sources.
  input wire logic scsi_req_pulse,
  input wire logic [2:0] scsi_phase,
  input wire logic scsi_atn,
  input wire logic arb_sel_done,
  input wire logic selected_pulse,
  input wire logic reselected_pulse,
  input wire logic [5:0] gross_err_src,
  input wire logic disconnect_pulse,
  input wire logic disconnect_expected,
  input wire logic scsi_rst,
  input wire logic parity_err_pulse,
  input wire logic sel_timeout_pulse,
  input wire logic gen_timer_pulse,
  input wire logic hth_timer_pulse,
  // One-cycle condition pulses.
  output byte_t ev_a,
  output tmr_t ev_b
);
  capture_state_s s_reg; // Registered state.
  capture_state_s s_next; // Next state.
  logic init; // Initiator role.
  logic [2:0] exp_phase; // Expected phase.

  assign init = mode[`MODE_INIT];
  assign exp_phase = mode[`MODE_PHASE_HI:`MODE_PHASE_LO];

  // Turn raw sources into condition pulses.
  always_comb begin
    s_next = s_reg;
    s_next.rst_prev = scsi_rst;
    s_next.atn_prev = scsi_atn;
    // Mismatch as initiator, attention rising as target.
    s_next.ev_a[`BIT_MA] = init ? (scsi_req_pulse && scsi_phase != exp_phase)
                         : (scsi_atn && !s_reg.atn_prev); // R08
    s_next.ev_a[`BIT_DONE] = arb_sel_done; // R09
    s_next.ev_a[`BIT_SEL] = selected_pulse && mode[`MODE_SEL_EN]; // R10
    s_next.ev_a[`BIT_RESEL] = reselected_pulse && mode[`MODE_RESEL_EN]; // R11
    s_next.ev_a[`BIT_GROSS] = |gross_err_src; // R12
    // Low-level mode reports every disconnect.
    s_next.ev_a[`BIT_DISC] = disconnect_pulse &&
      ((init && !disconnect_expected) || mode[`MODE_LOWLVL]); // R13
    // Edge only, so a long reset pulse gives one condition.
    s_next.ev_a[`BIT_RST] = scsi_rst && !s_reg.rst_prev; // R14
    s_next.ev_a[`BIT_PARITY] = parity_err_pulse && mode[`MODE_PAR_EN]; // R15
    s_next.ev_b = {sel_timeout_pulse, gen_timer_pulse,
                   hth_timer_pulse}; // R17 R18 R19
  end

  // Register the stage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ev_a = s_reg.ev_a;
  assign ev_b = s_reg.ev_b;

  rst_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
    scsi_rst && $past(scsi_rst) && $past(rst_n) |=> !ev_a[`BIT_RST])
    else $error("reset edge gave a second condition");
endmodule : scsi_condition_capture

// ---- scsi_interrupt_enable_status.sv ----
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "scsi_irq_cfg.svh"
module scsi_interrupt_enable_status import scsi_irq_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Condition sources from the SCSI core.
  input wire logic scsi_req_pulse,
  input wire logic [2:0] scsi_phase,
  input wire logic scsi_atn,
  input wire logic arb_sel_done,
  input wire logic selected_pulse,
  input wire logic reselected_pulse,
  input wire logic [5:0] gross_err_src,
  input wire logic disconnect_pulse,
  input wire logic disconnect_expected,
  input wire logic scsi_rst,
  input wire logic parity_err_pulse,
  input wire logic sel_timeout_pulse,
  input wire logic gen_timer_pulse,
  input wire logic hth_timer_pulse,
  // DMA side summary and test adder.
  input wire logic dma_pending_flag,
  input wire logic [31:0] adder_sum,
  // Host interrupt request.
  output logic irq_n
);
  // Register byte addresses.
  localparam logic [11:0] A_ADDER = `IDX_ADDER << `REG_SHIFT;
  localparam logic [11:0] A_EN_A = `IDX_EN_A << `REG_SHIFT;
  localparam logic [11:0] A_EN_B = `IDX_EN_B << `REG_SHIFT;
  localparam logic [11:0] A_ST_A = `IDX_ST_A << `REG_SHIFT;
  localparam logic [11:0] A_ST_B = `IDX_ST_B << `REG_SHIFT;
  localparam logic [11:0] A_SUM = `IDX_SUMMARY << `REG_SHIFT;
  localparam logic [11:0] A_MODE = `IDX_MODE << `REG_SHIFT;

  core_state_s s_reg; // Registered state.
  core_state_s s_next; // Next state.
  byte_t ev_a; // Conditions of the first group.
  tmr_t ev_b; // Timer conditions.
  logic setup; // APB setup phase.
  logic access; // APB access phase.
  logic wr; // Write taking effect.
  logic rd_a; // Clearing read of first status.
  logic rd_b; // Clearing read of second status.
  logic hit; // Address is mapped.
  logic stack_on; // New conditions are held back.
  byte_t count_a; // First-group bits that raise pending.
  logic [31:0] rd_val; // Read data chosen at setup.

  // Condition pulses arrive one cycle after their sources.
  scsi_condition_capture scsi_condition_capture_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .mode(s_reg.mode),
    .scsi_req_pulse(scsi_req_pulse),
    .scsi_phase(scsi_phase),
    .scsi_atn(scsi_atn),
    .arb_sel_done(arb_sel_done),
    .selected_pulse(selected_pulse),
    .reselected_pulse(reselected_pulse),
    .gross_err_src(gross_err_src),
    .disconnect_pulse(disconnect_pulse),
    .disconnect_expected(disconnect_expected),
    .scsi_rst(scsi_rst),
    .parity_err_pulse(parity_err_pulse),
    .sel_timeout_pulse(sel_timeout_pulse),
    .gen_timer_pulse(gen_timer_pulse),
    .hth_timer_pulse(hth_timer_pulse),
    .ev_a(ev_a),
    .ev_b(ev_b)
  );

  // Bus phase decode; the slave never inserts wait states.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd_a = access && !pwrite && paddr == A_ST_A;
  assign rd_b = access && !pwrite && paddr == A_ST_B;
  assign pready = 1'b1;
  assign prdata = s_reg.prdata;

  // Address match over every mapped register.
  always_comb begin
    case (paddr)
      A_ADDER, A_EN_A, A_EN_B, A_ST_A, A_ST_B, A_SUM, A_MODE: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error in the access phase.
  assign pslverr = access && !hit;

  // Read data is picked at setup so a clearing read knows which bits
  // software has actually seen.
  always_comb begin
    case (paddr)
      A_ADDER: begin
        rd_val = adder_sum;
      end
      A_EN_A: begin
        rd_val = {24'h000000, s_reg.scsi_irq_enable_a};
      end
      A_EN_B: begin
        rd_val = {29'h0000000, s_reg.scsi_irq_enable_b};
      end
      A_ST_A: begin
        rd_val = {24'h000000, s_reg.scsi_irq_status_a}; // R20
      end
      A_ST_B: begin
        rd_val = {29'h0000000, s_reg.scsi_irq_status_b}; // R20
      end
      A_SUM: begin
        rd_val = {30'h00000000, s_reg.scsi_pending_flag,
                  dma_pending_flag};
      end
      A_MODE: begin
        rd_val = {24'h000000, s_reg.mode};
      end
      default: begin
        rd_val = 32'h00000000;
      end
    endcase
  end

  // Stacking runs while either summary flag is up.
  assign stack_on = s_reg.scsi_pending_flag || dma_pending_flag; // R04

  // Fatal bits always count; non-fatal ones only while enabled. The
  // mismatch bit is non-fatal only in target mode.
  always_comb begin
    count_a = `MASK_FATAL_A | s_reg.scsi_irq_enable_a; // R03
    if (s_reg.mode[`MODE_INIT]) begin
      count_a = count_a | `MASK_MA;
    end
  end

  // Next-state logic of registers, stack and summary flags.
  always_comb begin
    s_next = s_reg;
    // Capture read data during the setup cycle.
    if (setup && !pwrite) begin
      s_next.prdata = rd_val;
    end
    // Register writes take effect in the access cycle.
    if (wr) begin
      case (paddr)
        A_EN_A: begin
          s_next.scsi_irq_enable_a = pwdata[7:0]; // R02
        end
        A_EN_B: begin
          s_next.scsi_irq_enable_b = pwdata[2:0]; // R16
        end
        A_MODE: begin
          s_next.mode = pwdata[7:0];
        end
        default: begin
          // Status, summary and adder words ignore writes.
          s_next.mode = s_reg.mode;
        end
      endcase
    end
    // First status: clear only what was shown, then let stacked
    // bits through; a same-cycle condition always lands somewhere.
    if (rd_a) begin
      s_next.scsi_irq_status_a = (s_reg.scsi_irq_status_a &
        ~s_reg.prdata[7:0]) | s_reg.stack_a | ev_a; // R22 R24
      s_next.stack_a = 8'h00;
    end else if (stack_on) begin
      s_next.stack_a = s_reg.stack_a | ev_a; // R04
    end else begin
      // Stacking off: held bits fall through.
      s_next.scsi_irq_status_a = s_reg.scsi_irq_status_a |
        s_reg.stack_a | ev_a; // R01 R07
      s_next.stack_a = 8'h00;
    end
    // Second status behaves the same way.
    if (rd_b) begin
      s_next.scsi_irq_status_b = (s_reg.scsi_irq_status_b &
        ~s_reg.prdata[2:0]) | s_reg.stack_b | ev_b; // R22 R24
      s_next.stack_b = 3'h0;
    end else if (stack_on) begin
      s_next.stack_b = s_reg.stack_b | ev_b; // R04
    end else begin
      s_next.scsi_irq_status_b = s_reg.scsi_irq_status_b |
        s_reg.stack_b | ev_b;
      s_next.stack_b = 3'h0;
    end
    // Track reads while the pending flag is up.
    s_next.seen_a = s_reg.scsi_pending_flag && (s_reg.seen_a || rd_a);
    s_next.seen_b = s_reg.scsi_pending_flag && (s_reg.seen_b || rd_b);
    // Once a read has begun the flag holds until both are read;
    // before that it follows the counting bits, so masking an
    // occurred non-fatal condition drops it.
    s_next.scsi_pending_flag =
      |(s_next.scsi_irq_status_a & count_a) ||
      |s_next.scsi_irq_status_b ||
      (s_reg.scsi_pending_flag && (s_next.seen_a || s_next.seen_b) &&
       !(s_next.seen_a && s_next.seen_b)); // R03 R07 R16 R21
    if (s_next.seen_a && s_next.seen_b) begin
      s_next.seen_a = 1'b0;
      s_next.seen_b = 1'b0;
    end
    // Request sets from enabled bits only and holds until a status
    // read; a later mask change cannot drop it.
    s_next.irq = (s_reg.irq && !(rd_a || rd_b)) ||
      |(s_next.scsi_irq_status_a & s_next.scsi_irq_enable_a) ||
      |(s_next.scsi_irq_status_b &
        s_next.scsi_irq_enable_b); // R01 R02 R05 R06
  end

  // State register with documented reset values.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.scsi_irq_enable_a <= `EN_A_RST;
      s_reg.scsi_irq_enable_b <= `EN_B_RST;
      s_reg.scsi_irq_status_a <= `ST_A_RST;
      s_reg.scsi_irq_status_b <= `ST_B_RST;
      s_reg.mode <= `MODE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Request output is active low.
  assign irq_n = !s_reg.irq;

  // All checks below share the core clock and are off during reset,
  // so a half-reset state never trips them.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // A read of the first status register over two phases.
  sequence read_a_seq;
    setup && !pwrite && paddr == A_ST_A ##1 access;
  endsequence

  // The request only rises from an enabled status bit.
  irq_cause_a: assert property ($rose(s_reg.irq) |-> // R01
    |(s_reg.scsi_irq_status_a & s_reg.scsi_irq_enable_a) ||
    |(s_reg.scsi_irq_status_b & s_reg.scsi_irq_enable_b))
    else $error("request rose without an enabled status bit");

  // An enabled condition raises the request one cycle later.
  unmask_irq_a: assert property (|(ev_a & s_reg.scsi_irq_enable_a) && // R02
    !stack_on && !rd_a && !wr |=> !irq_n)
    else $error("enabled condition did not raise the request");

  // The request holds until a status register is read.
  irq_latch_a: assert property (s_reg.irq && !rd_a && !rd_b // R05
    |=> s_reg.irq)
    else $error("request dropped without a status read");

  // Masking an enable never drops a raised request.
  mask_keep_a: assert property (s_reg.irq && wr && paddr == A_EN_A // R06
    && !rd_a && !rd_b |=> !irq_n [*1])
    else $error("clearing an enable dropped the request");

  // A fatal condition sets the pending flag even when masked.
  fatal_sip_a: assert property (|(ev_a & `MASK_FATAL_A) && !stack_on // R03
    && !rd_a |=> s_reg.scsi_pending_flag)
    else $error("fatal condition did not set the pending flag");

  // While pending, new conditions wait in the stack.
  stack_hold_a: assert property (stack_on && !rd_a && ev_a != 8'h00 // R04
    |=> (s_reg.stack_a & $past(ev_a)) == $past(ev_a))
    else $error("condition was not stacked while pending");

  // One status read alone never clears the pending flag.
  both_reads_a: assert property (s_reg.scsi_pending_flag && // R21
    s_reg.seen_a && !s_reg.seen_b && !rd_b |=> s_reg.scsi_pending_flag)
    else $error("pending flag cleared before both reads");

  // A condition in the clearing cycle survives the read.
  clear_keep_a: assert property (read_a_seq |-> ##1 // R22 R24
    ((s_reg.scsi_irq_status_a | s_reg.stack_a) & $past(ev_a))
    == $past(ev_a))
    else $error("condition lost during clearing read");

  // The status read shows every bit, enabled or not.
  read_show_a: assert property (setup && !pwrite && paddr == A_ST_A // R20
    |=> prdata[7:0] == $past(s_reg.scsi_irq_status_a))
    else $error("status read did not show all conditions");

  // A read of the second status register over two phases.
  sequence read_b_seq;
    setup && !pwrite && paddr == A_ST_B ##1 access;
  endsequence

  // The clearing read empties the stack into the status register.
  stack_drop_a: assert property (read_a_seq |=> // R22
    s_reg.stack_a == 8'h00)
    else $error("stack not emptied by the status read");

  // A timer condition sets the pending flag whatever its enable.
  sip_timer_a: assert property (|ev_b && !stack_on && !rd_b // R16
    |=> s_reg.scsi_pending_flag)
    else $error("timer condition did not set the pending flag");

  // Selection is reported only while its response is enabled.
  sel_gate_a: assert property (selected_pulse && // R10
    !s_reg.mode[`MODE_SEL_EN] |=> !ev_a[`BIT_SEL])
    else $error("selection reported with its response off");

  // Reselection is reported only while its response is enabled.
  resel_gate_a: assert property (reselected_pulse && // R11
    !s_reg.mode[`MODE_RESEL_EN] |=> !ev_a[`BIT_RESEL])
    else $error("reselection reported with its response off");

  // Outside initiator and low-level modes no disconnect is reported.
  udc_gate_a: assert property (disconnect_pulse && // R13
    !s_reg.mode[`MODE_INIT] && !s_reg.mode[`MODE_LOWLVL]
    |=> !ev_a[`BIT_DISC])
    else $error("disconnect reported outside initiator mode");

  // Parity errors are reported only while checking is enabled.
  par_gate_a: assert property (parity_err_pulse && // R15
    !s_reg.mode[`MODE_PAR_EN] |=> !ev_a[`BIT_PARITY])
    else $error("parity error reported with checking off");

  // The second status read shows every timer bit.
  read_show_b: assert property (setup && !pwrite && paddr == A_ST_B // R20
    |=> prdata[2:0] == $past(s_reg.scsi_irq_status_b))
    else $error("second status read did not show all conditions");

  // A timer condition in the clearing cycle survives the read.
  clear_keep_b: assert property (read_b_seq |-> ##1 // R24
    ((s_reg.scsi_irq_status_b | s_reg.stack_b) & $past(ev_b))
    == $past(ev_b))
    else $error("timer condition lost during clearing read");
endmodule : scsi_interrupt_enable_status

// ---- host_apb_model.sv ----
`timescale 1ns/10ps
module host_apb_model (
  // Clock.
  input wire logic core_clk,
  // APB request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // APB answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus is idle from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Status reads need spacing so the clear settles before the next.
    if (a[11:3] == 9'h021) repeat (12) @(posedge core_clk);
  endtask : xfer
endmodule : host_apb_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "scsi_irq_cfg.svh"
module tb_top import scsi_irq_pkg::*;;
  // Clock, reset and bus wires.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // Condition pulses, one bit per source, and level sources.
  logic [14:0] ev = '0;
  logic atn = 1'b0;
  logic srst = 1'b0;
  logic dexp = 1'b0;
  logic dma = 1'b0;
  int fail_count = 0;
  int checked = 0;
  // Byte addresses of the registers.
  localparam logic [11:0] A_ENA = 12'h100;
  localparam logic [11:0] A_ENB = 12'h104;
  localparam logic [11:0] A_STA = 12'h108;
  localparam logic [11:0] A_STB = 12'h10c;
  localparam logic [11:0] A_SUM = 12'h114;
  localparam logic [11:0] A_MODE = 12'h118;

  // Free-running 10 MHz clock.
  always #50 core_clk = ~core_clk;

  host_apb_model host_apb_model_i (.core_clk(core_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  scsi_interrupt_enable_status scsi_interrupt_enable_status_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scsi_req_pulse(ev[0]),
    .scsi_phase(3'h2), .scsi_atn(atn), .arb_sel_done(ev[1]),
    .selected_pulse(ev[2]), .reselected_pulse(ev[3]),
    .gross_err_src(ev[9:4]), .disconnect_pulse(ev[10]),
    .disconnect_expected(dexp), .scsi_rst(srst),
    .parity_err_pulse(ev[11]), .sel_timeout_pulse(ev[12]),
    .gen_timer_pulse(ev[13]), .hth_timer_pulse(ev[14]),
    .dma_pending_flag(dma), .adder_sum(32'h1234abcd), .irq_n(irq_n));

  // Counted comparison.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  // Register access helpers.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host_apb_model_i.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    host_apb_model_i.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd

  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(n, e, r);
  endtask : rdc

  // Request level sampled mid-cycle, clear of the register update.
  task automatic irq_is(input logic e);
    @(negedge core_clk);
    chk("irq_n", {31'h0, e}, {31'h0, irq_n});
  endtask : irq_is

  // One-cycle pulse, then time for the capture pipeline.
  task automatic fire(input logic [14:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask : fire

  // Masked condition under a mode: expected status, no request.
  task automatic one(input byte_t md, input logic [14:0] m,
                     input logic dx, input byte_t ea, input tmr_t eb);
    wr(A_MODE, {24'h0, md});
    dexp <= dx;
    fire(m);
    irq_is(1'b1);
    rdc("status_a", A_STA, {24'h0, ea});
    rdc("status_b", A_STB, {29'h0, eb});
  endtask : one

  // Reset values, access kinds and a refused address.
  task automatic regs;
    logic [31:0] r;
    logic e;
    rdc("en_a", A_ENA, 32'h0);
    rdc("en_b", A_ENB, 32'h0);
    rdc("st_a", A_STA, 32'h0);
    rdc("summary", A_SUM, 32'h0);
    irq_is(1'b1);
    wr(A_ENA, 32'ha5);
    rdc("en_a", A_ENA, 32'ha5);
    wr(A_ENA, 32'h0);
    wr(A_ENB, 32'hff);
    rdc("en_b", A_ENB, 32'h7);
    wr(A_ENB, 32'h0);
    wr(A_STA, 32'hff);
    rdc("st_a", A_STA, 32'h0);
    rdc("adder", 12'h0f0, 32'h1234abcd);
    host_apb_model_i.xfer(1'b0, 12'h7fc, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask : regs

  // Masked fatal sets pending; it drops only after both reads.
  task automatic masked;
    wr(A_MODE, 32'h0);
    fire(15'h0010);
    rdc("summary", A_SUM, 32'h2);
    irq_is(1'b1);
    rdc("st_a", A_STA, 32'h08);
    rdc("summary", A_SUM, 32'h2);
    rdc("st_b", A_STB, 32'h0);
    rdc("summary", A_SUM, 32'h0);
  endtask : masked

  // Masked non-fatal leaves pending clear and blocks nothing.
  task automatic nonfatal;
    wr(A_MODE, 32'h08);
    fire(15'h0004);
    rdc("summary", A_SUM, 32'h0);
    wr(A_ENA, 32'h08);
    fire(15'h0040);
    irq_is(1'b0);
    rdc("st_a", A_STA, 32'h28);
    irq_is(1'b1);
    rdc("st_b", A_STB, 32'h0);
    wr(A_ENA, 32'h0);
  endtask : nonfatal

  // Latched request survives masking and clears on the read.
  task automatic latched;
    wr(A_ENA, 32'h08);
    fire(15'h0100);
    irq_is(1'b0);
    repeat (20) @(posedge core_clk);
    irq_is(1'b0);
    wr(A_ENA, 32'h0);
    irq_is(1'b0);
    rdc("st_a", A_STA, 32'h08);
    irq_is(1'b1);
    rdc("st_b", A_STB, 32'h0);
    // Enabled non-fatal counts; masking it afterwards drops pending.
    wr(A_ENA, 32'h40);
    fire(15'h0002);
    rdc("summary", A_SUM, 32'h2);
    wr(A_ENA, 32'h0);
    rdc("summary", A_SUM, 32'h0);
    rdc("st_a", A_STA, 32'h40);
    rdc("st_b", A_STB, 32'h0);
  endtask : latched

  // Conditions behind a set pending flag appear after the read.
  task automatic stack;
    wr(A_MODE, 32'h04);
    fire(15'h0020);
    fire(15'h0800);
    rdc("st_a", A_STA, 32'h08);
    rdc("st_a", A_STA, 32'h01);
    rdc("st_b", A_STB, 32'h0);
    dma <= 1'b1;
    fire(15'h0200);
    rdc("st_a", A_STA, 32'h0);
    dma <= 1'b0;
    rdc("st_a", A_STA, 32'h08);
    rdc("st_b", A_STB, 32'h0);
  endtask : stack

  // Level sources: reset edge and target attention.
  task automatic levels;
    wr(A_MODE, 32'h0);
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc("st_a", A_STA, 32'h02);
    rdc("st_a", A_STA, 32'h0);
    rdc("st_b", A_STB, 32'h0);
    srst <= 1'b0;
    atn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc("st_a", A_STA, 32'h80);
    atn <= 1'b0;
  endtask : levels

  // A condition landing with the clearing read must not be lost.
  task automatic race;
    logic [31:0] r1, r2;
    // The pulse reaches the core in the access cycle of the first read.
    fork
      rd(A_STA, r1);
      begin
        @(posedge core_clk);
        ev <= 15'h0010;
        @(posedge core_clk);
        ev <= '0;
      end
    join
    rd(A_STA, r2);
    chk("shown", 32'h0, r1);
    chk("kept", 32'h08, r2);
    rdc("st_b", A_STB, 32'h0);
  endtask : race

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    regs;
    masked;
    nonfatal;
    latched;
    stack;
    one(8'h21, 15'h0001, 1'b0, 8'h80, 3'h0);
    one(8'h41, 15'h0001, 1'b0, 8'h00, 3'h0);
    one(8'h00, 15'h0002, 1'b0, 8'h40, 3'h0);
    one(8'h00, 15'h0004, 1'b0, 8'h00, 3'h0);
    one(8'h08, 15'h0004, 1'b0, 8'h20, 3'h0);
    one(8'h00, 15'h0008, 1'b0, 8'h00, 3'h0);
    one(8'h10, 15'h0008, 1'b0, 8'h10, 3'h0);
    for (int k = 0; k < 6; k++) begin
      one(8'h00, 15'h0010 << k, 1'b0, 8'h08, 3'h0);
    end
    one(8'h01, 15'h0400, 1'b0, 8'h04, 3'h0);
    one(8'h01, 15'h0400, 1'b1, 8'h00, 3'h0);
    one(8'h00, 15'h0400, 1'b0, 8'h00, 3'h0);
    one(8'h03, 15'h0400, 1'b1, 8'h04, 3'h0);
    one(8'h00, 15'h0800, 1'b0, 8'h00, 3'h0);
    one(8'h04, 15'h0800, 1'b0, 8'h01, 3'h0);
    one(8'h00, 15'h1000, 1'b0, 8'h00, 3'h4);
    one(8'h00, 15'h2000, 1'b0, 8'h00, 3'h2);
    one(8'h00, 15'h4000, 1'b0, 8'h00, 3'h1);
    levels;
    race;
    wrap_up;
  end

  // Hang guard, far beyond the roughly 1400 cycles the run needs.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up;
  end

  // Verdict.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
endmodule : tb_top
